// ===== rtl/i2cms_defs.svh
// Functional notes
// - Own seven-bit slave address, resets 0x55
// - Ten-bit slave uses three upper extension bits
// - Slave waits setup value cycles, one if zero
// - Descriptor bit 0: write zero, read one
// - Target address low 7:1, high 10:8
// - Bit 11 prefixes start-byte procedure
// - Address kind: general call, 7-bit, 10-bit
// - No stop: park, repeated start next
// - Stop bit set ends with STOP
// - Read exactly length bytes, then not-acknowledge
// - Write length bytes, refilled from transmit side
// - Hold SCL low while receive side full
`ifndef I2CMS_DEFS_SVH
`define I2CMS_DEFS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define I2CMS_ADR_CTRL      8'h00
`define I2CMS_ADR_SLAVE     8'h04
`define I2CMS_ADR_MASTER    8'h0c
`define I2CMS_ADR_TXDATA    8'h10
`define I2CMS_ADR_RXDATA    8'h14
`define I2CMS_ADR_STATUS    8'h18

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define I2CMS_CTRL_GO       0
`define I2CMS_CTRL_S10      1
`define I2CMS_CTRL_SEN      2
`define I2CMS_OWN_LO        6:0
`define I2CMS_OWN_HI        9:7
`define I2CMS_SETUP         31:16
`define I2CMS_SLAVE_RST     32'h000f_0055
`define I2CMS_SLAVE_MASK    32'hffff_03ff
`define I2CMS_MASTER_RST    32'h0000_0000
`define I2CMS_MASTER_MASK   32'h03ff_ffff
`define I2CMS_DIR           0
`define I2CMS_TGT_LO        7:1
`define I2CMS_TGT_HI        10:8
`define I2CMS_SBYTE         11
`define I2CMS_KIND          13:12
`define I2CMS_STOP          14
`define I2CMS_LEN           25:15
`define I2CMS_KIND_GCALL    2'h0
`define I2CMS_KIND_A7       2'h1
`define I2CMS_KIND_A10      2'h2
`define I2CMS_BYTE_SB       8'h01
`define I2CMS_BYTE_GCALL    8'h00
`define I2CMS_A10_MARK      5'h1e
`define I2CMS_ST_BUSY       0
`define I2CMS_ST_NACK       1
`define I2CMS_ST_TXFULL     2
`define I2CMS_ST_RXVALID    3
`define I2CMS_ST_ADDRESSED  4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define I2CMS_KCLK_HZ       16000000
`define I2CMS_SCL_HZ        100000
`define I2CMS_HALF_CYC      (`I2CMS_KCLK_HZ / (2 * `I2CMS_SCL_HZ))
`define I2CMS_LAST_BIT      4'h8

`endif

// ===== rtl/i2cms_pkg.sv
package i2cms_pkg;

   typedef enum logic [3:0] {
      M_IDLE, M_START, M_NEXT, M_LO, M_HI, M_RSTART, M_STOP, M_PARK
   } i2cms_mst_t;

   typedef enum logic [2:0] {
      P_SB, P_A1, P_A2, P_A3, P_DATA
   } i2cms_phase_t;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_TXACK, S_STR_RX, S_STR_TX, S_SETUP
   } i2cms_slv_t;

   typedef struct packed {
      logic        s10;
      logic        sen;
      logic [31:0] slave_control;
      logic [31:0] mtc;
      logic [7:0]  tx_data;
      logic        tx_tgl;
      logic        rx_seen;
      logic        go_tgl;
      logic        cfg_tgl;
      logic        ack;
      logic [31:0] dat;
   } i2cms_bus_t;

   typedef struct packed {
      i2cms_mst_t   m_st;
      i2cms_phase_t m_ph;
      logic [15:0]  m_cnt;
      logic [3:0]   m_bit;
      logic [7:0]   m_sh;
      logic         m_rd;
      logic         m_pushed;
      logic [10:0]  m_left;
      logic [31:0]  mtc;
      logic [31:0]  slave_control;
      logic         s10;
      logic         sen;
      i2cms_slv_t   s_st;
      i2cms_slv_t   s_nx;
      logic [3:0]   s_cnt;
      logic [7:0]   s_sh;
      logic         s_m10;
      logic [15:0]  s_dly;
      logic         scl_d;
      logic         sda_d;
      logic         go_seen;
      logic         cfg_seen;
      logic         tx_seen;
      logic         rx_tgl;
      logic [7:0]   rx_data;
      logic         busy;
      logic         nack;
      logic         addressed;
      logic         m_scl;
      logic         m_sda;
      logic         s_scl;
      logic         s_sda;
      logic         scl_oe;
      logic         sda_oe;
      logic         pin_lo;
   } i2cms_kern_t;

endpackage

// ===== rtl/i2cms_sync.sv
`timescale 1ns/1ps
module i2cms_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } i2cms_sync_t;

   i2cms_sync_t r_r;
   i2cms_sync_t r_nxt;

   always_comb begin
      r_nxt    = r_r;
      r_nxt.s1 = d;
      r_nxt.s2 = r_r.s1;
   end

   always_ff @(posedge clk) begin
      r_r <= r_nxt;
   end

   assign q = r_r.s2;
endmodule

// ===== rtl/i2cms_core.sv
`timescale 1ns/1ps
`include "i2cms_defs.svh"
module i2cms_core import i2cms_pkg::*; #(
   parameter int unsigned HALF_CYC = `I2CMS_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        kclk,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   i2cms_bus_t  b_r;
   i2cms_bus_t  b_nxt;
   i2cms_kern_t k_r;
   i2cms_kern_t k_nxt;
   logic [6:0]  k_in;
   logic [4:0]  b_in;
   logic        k_rst;
   logic        scl_q;
   logic        sda_q;
   logic        go_q;
   logic        cfg_q;
   logic        tx_q;
   logic        rxs_q;
   logic        busy_q;
   logic        nack_q;
   logic        adr_q;
   logic        txs_q;
   logic        rxt_q;

   // ------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------
   i2cms_sync #(.W(7)) u_to_kern (
      .clk (kclk),
      .d   ({reset, scl_i, sda_i, b_r.go_tgl, b_r.cfg_tgl, b_r.tx_tgl, b_r.rx_seen}),
      .q   (k_in)
   );
   i2cms_sync #(.W(5)) u_to_bus (
      .clk (clk),
      .d   ({k_r.busy, k_r.nack, k_r.addressed, k_r.tx_seen, k_r.rx_tgl}),
      .q   (b_in)
   );
   assign {k_rst, scl_q, sda_q, go_q, cfg_q, tx_q, rxs_q} = k_in;
   assign {busy_q, nack_q, adr_q, txs_q, rxt_q} = b_in;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   logic req;
   logic tx_full;
   logic rx_valid;
   assign req      = wb_cyc_i & wb_stb_i & ~b_r.ack;
   assign tx_full  = b_r.tx_tgl ^ txs_q;
   assign rx_valid = rxt_q ^ b_r.rx_seen;

   always_comb begin
      b_nxt     = b_r;
      b_nxt.ack = req;
      if (req && wb_we_i) begin
         unique case (wb_adr_i)
            `I2CMS_ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  b_nxt.s10     = wb_dat_i[`I2CMS_CTRL_S10];
                  b_nxt.sen     = wb_dat_i[`I2CMS_CTRL_SEN];
                  b_nxt.cfg_tgl = ~b_r.cfg_tgl;
                  if (wb_dat_i[`I2CMS_CTRL_GO] && !busy_q) begin
                     b_nxt.go_tgl = ~b_r.go_tgl;
                  end
               end
            end
            `I2CMS_ADR_SLAVE: begin
               b_nxt.slave_control     = merge(b_r.slave_control, wb_dat_i, wb_sel_i, `I2CMS_SLAVE_MASK);
               b_nxt.cfg_tgl = ~b_r.cfg_tgl;
            end
            `I2CMS_ADR_MASTER: b_nxt.mtc = merge(b_r.mtc, wb_dat_i, wb_sel_i, `I2CMS_MASTER_MASK);
            `I2CMS_ADR_TXDATA: begin
               if (wb_sel_i[0] && !tx_full) begin
                  b_nxt.tx_data = wb_dat_i[7:0];
                  b_nxt.tx_tgl  = ~b_r.tx_tgl;
               end
            end
            default: ;
         endcase
      end
      if (req) begin
         unique case (wb_adr_i)
            `I2CMS_ADR_CTRL:   b_nxt.dat = {29'h0000_0000, b_r.sen, b_r.s10, 1'b0};
            `I2CMS_ADR_SLAVE:  b_nxt.dat = b_r.slave_control;
            `I2CMS_ADR_MASTER: b_nxt.dat = b_r.mtc;
            `I2CMS_ADR_RXDATA: b_nxt.dat = {24'h00_0000, k_r.rx_data};
            `I2CMS_ADR_STATUS: b_nxt.dat = {27'h000_0000, adr_q, rx_valid, tx_full, nack_q, busy_q};
            default:           b_nxt.dat = 32'h0000_0000;
         endcase
         if (!wb_we_i && wb_adr_i == `I2CMS_ADR_RXDATA && rx_valid) begin
            b_nxt.rx_seen = ~b_r.rx_seen;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         b_r     <= '0;
         b_r.slave_control <= `I2CMS_SLAVE_RST;
         b_r.mtc <= `I2CMS_MASTER_RST;
      end else begin
         b_r <= b_nxt;
      end
   end

   assign wb_ack_o = b_r.ack;
   assign wb_dat_o = b_r.dat;

   // ------------------------------------------------------------
   // Link engine
   // ------------------------------------------------------------
   logic        go_ev;
   logic        tx_av;
   logic        rx_full;
   logic        tick;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic [15:0] half_ld;
   logic [15:0] setup_ld;
   logic        m_byte_rd;
   logic        m_ack;
   logic        s_match;

   assign go_ev     = go_q ^ k_r.go_seen;
   assign tx_av     = tx_q ^ k_r.tx_seen;
   assign rx_full   = k_r.rx_tgl ^ rxs_q;
   assign tick      = k_r.m_cnt == 16'h0000;
   assign scl_rise  = scl_q & ~k_r.scl_d;
   assign scl_fall  = ~scl_q & k_r.scl_d;
   assign bus_start = scl_q & k_r.scl_d & k_r.sda_d & ~sda_q;
   assign bus_stop  = scl_q & k_r.scl_d & ~k_r.sda_d & sda_q;
   assign half_ld   = 16'(HALF_CYC - 1);
   assign setup_ld  = (k_r.slave_control[`I2CMS_SETUP] == 16'h0000) ? 16'h0000 : k_r.slave_control[`I2CMS_SETUP] - 16'h0001;
   assign m_byte_rd = k_r.mtc[`I2CMS_DIR] && k_r.mtc[`I2CMS_KIND] != `I2CMS_KIND_GCALL;

   always_comb begin
      k_nxt         = k_r;
      k_nxt.scl_d   = scl_q;
      k_nxt.sda_d   = sda_q;
      k_nxt.go_seen = go_q;
      k_nxt.m_cnt   = tick ? 16'h0000 : k_r.m_cnt - 16'h0001;
      m_ack         = 1'b0;
      s_match       = 1'b0;
      if (cfg_q != k_r.cfg_seen) begin
         k_nxt.cfg_seen = cfg_q;
         k_nxt.slave_control      = b_r.slave_control;
         k_nxt.s10      = b_r.s10;
         k_nxt.sen      = b_r.sen;
      end
      // Master side
      unique case (k_r.m_st)
         M_IDLE, M_PARK: begin
            if (go_ev) begin
               k_nxt.mtc    = b_r.mtc;
               k_nxt.nack   = 1'b0;
               k_nxt.m_ph   = b_r.mtc[`I2CMS_SBYTE] ? P_SB : P_A1;
               k_nxt.m_left = b_r.mtc[`I2CMS_LEN];
               k_nxt.m_cnt  = half_ld;
               k_nxt.m_bit  = 4'h0;
               k_nxt.m_st   = (k_r.m_st == M_PARK) ? M_RSTART : M_START;
               k_nxt.m_sda  = (k_r.m_st == M_IDLE);
            end
         end
         M_START: begin
            if (tick) begin
               k_nxt.m_scl = 1'b1;
               k_nxt.m_st  = M_NEXT;
            end
         end
         M_RSTART: begin
            if (k_r.m_bit == 4'h0 && tick) begin
               k_nxt.m_scl = 1'b0;
               k_nxt.m_bit = 4'h1;
               k_nxt.m_cnt = half_ld;
            end else if (k_r.m_bit == 4'h1 && scl_q && tick) begin
               k_nxt.m_sda = 1'b1;
               k_nxt.m_cnt = half_ld;
               k_nxt.m_st  = M_START;
            end
         end
         M_NEXT: begin
            k_nxt.m_bit    = 4'h0;
            k_nxt.m_cnt    = half_ld;
            k_nxt.m_pushed = 1'b0;
            k_nxt.m_rd     = 1'b0;
            k_nxt.m_st     = M_LO;
            unique case (k_r.m_ph)
               P_SB: k_nxt.m_sh = `I2CMS_BYTE_SB;
               P_A1: begin
                  unique case (k_r.mtc[`I2CMS_KIND])
                     `I2CMS_KIND_A7:  k_nxt.m_sh = {k_r.mtc[`I2CMS_TGT_LO], k_r.mtc[`I2CMS_DIR]};
                     `I2CMS_KIND_A10: k_nxt.m_sh = {`I2CMS_A10_MARK, k_r.mtc[10:9], 1'b0};
                     default:         k_nxt.m_sh = `I2CMS_BYTE_GCALL;
                  endcase
               end
               P_A2: k_nxt.m_sh = {k_r.mtc[8], k_r.mtc[`I2CMS_TGT_LO]};
               P_A3: k_nxt.m_sh = {`I2CMS_A10_MARK, k_r.mtc[10:9], 1'b1};
               P_DATA: begin
                  if (k_r.m_left == 11'h000) begin
                     k_nxt.m_st  = k_r.mtc[`I2CMS_STOP] ? M_STOP : M_PARK;
                     k_nxt.m_sda = k_r.mtc[`I2CMS_STOP];
                  end else if (m_byte_rd) begin
                     k_nxt.m_rd = 1'b1;
                  end else if (tx_av) begin
                     k_nxt.m_sh    = b_r.tx_data;
                     k_nxt.tx_seen = tx_q;
                  end else begin
                     k_nxt.m_st = M_NEXT;
                  end
               end
               default: ;
            endcase
         end
         M_LO: begin
            k_nxt.m_scl = 1'b1;
            if (k_r.m_bit == `I2CMS_LAST_BIT) begin
               k_nxt.m_sda = k_r.m_rd && k_r.m_left != 11'h001;
            end else begin
               k_nxt.m_sda = !k_r.m_rd && !k_r.m_sh[7];
            end
            if (k_r.m_rd && k_r.m_bit == `I2CMS_LAST_BIT && !k_r.m_pushed) begin
               k_nxt.m_cnt = half_ld;
               if (!rx_full) begin
                  k_nxt.rx_data  = k_r.m_sh;
                  k_nxt.rx_tgl   = ~k_r.rx_tgl;
                  k_nxt.m_pushed = 1'b1;
               end
            end else if (tick) begin
               k_nxt.m_scl = 1'b0;
               k_nxt.m_cnt = half_ld;
               k_nxt.m_st  = M_HI;
            end
         end
         M_HI: begin
            if (!scl_q) begin
               k_nxt.m_cnt = half_ld;
            end else if (tick) begin
               k_nxt.m_scl = 1'b1;
               k_nxt.m_cnt = half_ld;
               if (k_r.m_bit != `I2CMS_LAST_BIT) begin
                  k_nxt.m_sh  = {k_r.m_sh[6:0], sda_q};
                  k_nxt.m_bit = k_r.m_bit + 4'h1;
                  k_nxt.m_st  = M_LO;
               end else begin
                  m_ack      = !sda_q;
                  k_nxt.m_st = M_NEXT;
                  unique case (k_r.m_ph)
                     P_SB: begin
                        k_nxt.m_ph  = P_A1;
                        k_nxt.m_bit = 4'h0;
                        k_nxt.m_sda = 1'b0;
                        k_nxt.m_st  = M_RSTART;
                     end
                     P_A1: k_nxt.m_ph = (k_r.mtc[`I2CMS_KIND] == `I2CMS_KIND_A10) ? P_A2 : P_DATA;
                     P_A2: begin
                        k_nxt.m_ph = k_r.mtc[`I2CMS_DIR] ? P_A3 : P_DATA;
                        if (k_r.mtc[`I2CMS_DIR]) begin
                           k_nxt.m_bit = 4'h0;
                           k_nxt.m_sda = 1'b0;
                           k_nxt.m_st  = M_RSTART;
                        end
                     end
                     P_A3:    k_nxt.m_ph = P_DATA;
                     default: k_nxt.m_left = k_r.m_left - 11'h001;
                  endcase
                  if (!k_r.m_rd && !m_ack && k_r.m_ph != P_SB) begin
                     // SDA is pulled low one cycle after SCL falls, in the stop state
                     k_nxt.nack  = 1'b1;
                     k_nxt.m_bit = 4'h0;
                     k_nxt.m_st  = M_STOP;
                  end
               end
            end
         end
         M_STOP: begin
            k_nxt.m_sda = 1'b1;
            if (k_r.m_bit == 4'h0 && tick) begin
               k_nxt.m_scl = 1'b0;
               k_nxt.m_bit = 4'h1;
               k_nxt.m_cnt = half_ld;
            end else if (k_r.m_bit == 4'h1 && scl_q && tick) begin
               k_nxt.m_sda = 1'b0;
               k_nxt.m_st  = M_IDLE;
            end
         end
         default: ;
      endcase
      k_nxt.busy = k_nxt.m_st != M_IDLE && k_nxt.m_st != M_PARK;
      // Slave side
      if (bus_stop || !k_r.sen || k_r.busy) begin
         k_nxt.s_st  = S_IDLE;
         k_nxt.s_scl = 1'b0;
         k_nxt.s_sda = 1'b0;
         k_nxt.s_m10 = k_r.s_m10 && !bus_stop;
      end else if (bus_start) begin
         k_nxt.s_st      = S_ADDR;
         k_nxt.s_cnt     = 4'h0;
         k_nxt.addressed = 1'b0;
      end else begin
         unique case (k_r.s_st)
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  k_nxt.s_sh  = {k_r.s_sh[6:0], sda_q};
                  k_nxt.s_cnt = k_r.s_cnt + 4'h1;
               end else if (scl_fall && k_r.s_cnt == `I2CMS_LAST_BIT) begin
                  k_nxt.s_cnt = 4'h0;
                  k_nxt.s_nx  = S_RX;
                  if (k_r.s_st == S_RX) begin
                     k_nxt.s_st  = S_STR_RX;
                     k_nxt.s_scl = 1'b1;
                  end else begin
                     if (!k_r.s10) begin
                        s_match    = k_r.s_sh[7:1] == k_r.slave_control[`I2CMS_OWN_LO];
                        k_nxt.s_nx = k_r.s_sh[0] ? S_TX : S_RX;
                     end else if (k_r.s_cnt == `I2CMS_LAST_BIT && k_r.s_sh[7:3] == `I2CMS_A10_MARK
                                  && k_r.s_sh[2:1] == k_r.slave_control[9:8]) begin
                        s_match    = !k_r.s_sh[0] || k_r.s_m10;
                        k_nxt.s_nx = k_r.s_sh[0] ? S_TX : S_ADDR;
                     end else if (k_r.s_sh == {k_r.slave_control[7], k_r.slave_control[`I2CMS_OWN_LO]} && k_r.s_m10 == 1'b0
                                  && k_r.s_nx == S_ADDR) begin
                        s_match     = 1'b1;
                        k_nxt.s_m10 = 1'b1;
                     end
                     k_nxt.s_sda     = s_match;
                     k_nxt.addressed = s_match;
                     k_nxt.s_st      = s_match ? S_ACK : S_IDLE;
                  end
               end
            end
            S_STR_RX: begin
               if (!rx_full) begin
                  k_nxt.rx_data = k_r.s_sh;
                  k_nxt.rx_tgl  = ~k_r.rx_tgl;
                  k_nxt.s_sda   = 1'b1;
                  k_nxt.s_dly   = setup_ld;
                  k_nxt.s_nx    = S_ACK;
                  k_nxt.s_st    = S_SETUP;
               end
            end
            S_SETUP: begin
               if (k_r.s_dly == 16'h0000) begin
                  k_nxt.s_scl = 1'b0;
                  k_nxt.s_st  = k_r.s_nx;
                  k_nxt.s_nx  = (k_r.s_nx == S_ACK) ? S_RX : k_r.s_nx;
               end else begin
                  k_nxt.s_dly = k_r.s_dly - 16'h0001;
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  k_nxt.s_sda = 1'b0;
                  k_nxt.s_cnt = 4'h0;
                  k_nxt.s_st  = (k_r.s_nx == S_TX) ? S_STR_TX : k_r.s_nx;
                  k_nxt.s_scl = k_r.s_nx == S_TX;
               end
            end
            S_STR_TX: begin
               k_nxt.s_scl = 1'b1;
               if (tx_av) begin
                  k_nxt.s_sh    = b_r.tx_data;
                  k_nxt.tx_seen = tx_q;
                  k_nxt.s_sda   = !b_r.tx_data[7];
                  k_nxt.s_dly   = setup_ld;
                  k_nxt.s_nx    = S_TX;
                  k_nxt.s_st    = S_SETUP;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  k_nxt.s_cnt = k_r.s_cnt + 4'h1;
                  k_nxt.s_sh  = {k_r.s_sh[6:0], 1'b0};
                  k_nxt.s_sda = !k_r.s_sh[6];
                  if (k_r.s_cnt == 4'h7) begin
                     k_nxt.s_sda = 1'b0;
                     k_nxt.s_st  = S_TXACK;
                  end
               end
            end
            S_TXACK: begin
               if (scl_rise && sda_q) begin
                  k_nxt.s_st = S_IDLE;
               end else if (scl_fall) begin
                  k_nxt.s_st  = S_STR_TX;
                  k_nxt.s_scl = 1'b1;
               end
            end
            default: ;
         endcase
      end
      k_nxt.scl_oe = k_nxt.m_scl | k_nxt.s_scl;
      k_nxt.sda_oe = k_nxt.m_sda | k_nxt.s_sda;
      k_nxt.pin_lo = 1'b0;
   end

   always_ff @(posedge kclk) begin
      if (k_rst) begin
         k_r      <= '0;
         k_r.slave_control  <= `I2CMS_SLAVE_RST;
         k_r.mtc  <= `I2CMS_MASTER_RST;
         k_r.m_st <= M_IDLE;
         k_r.m_ph <= P_A1;
         k_r.s_st <= S_IDLE;
         k_r.s_nx <= S_IDLE;
         // Idle bus level, so no false edge after reset
         k_r.scl_d <= 1'b1;
         k_r.sda_d <= 1'b1;
      end else begin
         k_r <= k_nxt;
      end
   end

   assign scl_o  = k_r.pin_lo;
   assign sda_o  = k_r.pin_lo;
   assign scl_oe = k_r.scl_oe;
   assign sda_oe = k_r.sda_oe;
endmodule

// ===== sim/i2cms_properties.sv
`timescale 1ns/1ps
module i2cms_properties #(
   parameter int unsigned HALF_CYC = 80
) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        kclk,
   input wire logic [7:0]  wb_adr_i,
   input wire logic        wb_we_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        scl_i,
   input wire logic        scl_oe,
   input wire logic        sda_o,
   input wire logic        sda_oe
);
   localparam int HWAIT = 2 * HALF_CYC;
   ack_pulse_a: assert property (@(posedge clk) disable iff (reset) wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   ack_delay_a: assert property (@(posedge clk) disable iff (reset) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_cause_a: assert property (@(posedge clk) disable iff (reset) !wb_stb_i |=> !wb_ack_o)
      else $error("ack unasked");
   reset_quiet_a: assert property (@(posedge clk) reset |=> !wb_ack_o)
      else $error("ack in reset");
   hole_zero_a: assert property (@(posedge clk) disable iff (reset)
      wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0000_0000) else $error("hole data");
   open_drain_a: assert property (@(posedge kclk) disable iff (reset) !sda_o)
      else $error("sda high");
   start_clock_a: assert property (@(posedge kclk) disable iff (reset)
      $rose(sda_oe) && scl_i && !scl_oe |-> ##[1:HWAIT] scl_oe) else $error("start");
   scl_low_a: assert property (@(posedge kclk) disable iff (reset) $rose(scl_oe) |-> scl_oe[*3])
      else $error("scl short");
endmodule
bind i2cms_core i2cms_properties #(.HALF_CYC(HALF_CYC)) chk (.*);

// ===== sim/i2cms_partner.sv
`timescale 1ns/1ps
module i2cms_partner #(
   parameter logic [6:0] ADDR = 7'h3a
) (
   input  wire logic  scl,
   input  wire logic  sda,
   output logic       pull,
   output logic [7:0] adr,
   output logic [7:0] got,
   output int         n_got,
   output int         n_start
);
   logic [7:0] sh;
   logic [7:0] pat = 8'hc5;
   logic       act = 0, first, hit, rd, nak;
   int         nb;
   initial pull = 0;
   initial n_got = 0;
   initial n_start = 0;
   // Frame start and stop seen on the wire
   always @(negedge sda) if (scl === 1'h1) begin
      n_start++;
      act = 1;
      first = 1;
      nb = 0;
   end
   always @(posedge sda) if (scl === 1'h1) act = 0;
   always @(posedge scl) if (act) begin
      if (nb < 8) sh = {sh[6:0], sda};
      nak = sda;
      nb++;
   end
   // Acknowledge and read data change just after SCL falls
   always @(negedge scl) if (act) begin
      pull = 0;
      if (nb == 8 && first) begin
         adr = sh;
         hit = sh[7:1] == ADDR;
         rd = sh[0];
         pull = hit;
      end else if (nb == 8) begin
         got = sh;
         n_got++;
         pull = !rd;
      end else if (nb == 9) begin
         act = hit && !(rd && nak && !first);
         first = 0;
         nb = 0;
      end
      if (act && hit && rd && !first && nb < 8) pull = !pat[7 - nb];
   end
endmodule

// ===== sim/i2c_master_slave_addressing_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module i2c_master_slave_addressing_tb;
   typedef struct packed {logic [31:0] m; logic [7:0] a; logic [1:0] s; logic k;} i2cms_row_t;
   i2cms_row_t  rows [7] = '{'{32'h0001_5074, 8'h74, 2'h1, 1'h0}, '{32'h0001_5075, 8'h75, 2'h1, 1'h0},
      '{32'h0000_4075, 8'h00, 2'h1, 1'h1}, '{32'h0000_6574, 8'hf4, 2'h1, 1'h1},
      '{32'h0000_5874, 8'h74, 2'h2, 1'h0}, '{32'h0000_5022, 8'h22, 2'h1, 1'h1}, '{32'h0000_d075, 8'h75, 2'h1, 1'h0}};
   logic        clk = 0, kclk = 0, reset = 1, we = 0, cyc = 0, stb = 0, ack, scl_oe, sda_oe, pull;
   logic [7:0]  adr = 8'h00, pa, pg;
   logic [31:0] wdat = 32'h0000_0000, q, st, rdat;
   int          pn, ps, n_fail = 0, checked = 0;
   wire         scl = !scl_oe;
   wire         sda = !(sda_oe || pull);
   always #5 clk = !clk;
   initial begin
      #2;
      forever #15 kclk = !kclk;
   end
   i2cms_core #(.HALF_CYC(4)) DUT (.clk(clk), .reset(reset), .kclk(kclk), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   i2cms_partner P (.scl(scl), .sda(sda), .pull(pull), .adr(pa), .got(pg), .n_got(pn), .n_start(ps));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      do @(posedge clk); while (ack !== 1'h1);
      q = rdat;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic run(input logic [31:0] m, input logic [7:0] ea, input logic [1:0] es, input logic ek);
      int left, n0, s0;
      left = m[0] ? 0 : int'(m[25:15]);
      n0 = pn;
      s0 = ps;
      wb(1'h1, 8'h0c, m);
      wb(1'h1, 8'h00, 32'h0000_0001);
      repeat (20) @(posedge clk);
      do begin
         wb(1'h0, 8'h18, 32'h0000_0000);
         st = q;
         if (st[3]) begin
            wb(1'h0, 8'h14, 32'h0000_0000);
            `CHK(q[7:0], 8'hc5)
         end
         if (!st[2] && left > 0) begin
            wb(1'h1, 8'h10, 32'h0000_0090 + left);
            left--;
         end
      end while (st[0] || st[3] || left > 0);
      repeat (10) @(posedge clk);
      `CHK(pa, ea)
      `CHK(2'(ps - s0), es)
      `CHK(st[1], ek)
      `CHK(pn - n0, ek ? 0 : int'(m[25:15]))
      if (!m[0] && m[25:15] != 11'h0) `CHK(pg, 8'h91)
   endtask
   task automatic finish_test();
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #500_000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      foreach (rows[i]) run(rows[i].m, rows[i].a, rows[i].s, rows[i].k);
      reset <= 1'h1;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      wb(1'h0, 8'h04, 32'h0000_0000);
      `CHK(q, 32'h000f_0055)
      wb(1'h0, 8'h0c, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      wb(1'h1, 8'h0c, 32'hffff_ffff);
      wb(1'h0, 8'h0c, 32'h0000_0000);
      `CHK(q, 32'h03ff_ffff)
      wb(1'h1, 8'h04, 32'h0005_ffff);
      wb(1'h0, 8'h04, 32'h0000_0000);
      `CHK(q, 32'h0005_03ff)
      wb(1'h0, 8'h20, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      run(32'h0000_1074, 8'h74, 2'h1, 1'h0);
      `CHK(scl_oe, 1'h1)
      run(32'h0000_5074, 8'h74, 2'h1, 1'h0);
      `CHK({scl_oe, sda_oe}, 2'h0)
      finish_test();
   end
endmodule
